// file: char_stream_if.sv
/*
 * Valid/ready character stream between the buffer core and its output FIFO.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface char_stream_if #(parameter int W = 9) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    // producer end
    modport src (output valid, output data, input ready);
    // consumer end
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: link_char_src.sv
/*
 * Link-side character source: free-running 200 ns recovered clock,
 * idle pairs between frames, frames sent whole.
 * Assumes frames are pushed in one go and are even in length.
 */
`timescale 1ns/1ps
`default_nettype none
module link_char_src
    import rx_elastic_pkg::*;
(
    // link pins
    output logic o_link_clk,
    output logic [7:0] o_char,
    output logic o_is_k
);
    logic [8:0] q [$];
    bit odd;
    bit busy;
    // free-running clock, idle comma at time zero
    initial
    begin
        o_link_clk = 1'b0;
        o_char = CH_K28_5;
        o_is_k = 1'b1;
        forever #100 o_link_clk = ~o_link_clk;
    end
    // next character on the falling edge, stable at the rising edge
    always @(negedge o_link_clk)
    begin
        if (q.size() != 0 && (busy || !odd))
        begin
            {o_is_k, o_char} = q.pop_front();
            busy = (q.size() != 0);
        end
        else
        begin
            o_is_k = !odd; // comma on the even slot
            o_char = odd ? CH_D16_2 : CH_K28_5;
        end
        odd = !odd;
    end
    // queue one character of a frame
    task automatic push(input logic [8:0] c);
        q.push_back(c);
    endtask
endmodule
`default_nettype wire

// file: rx_char_fifo.sv
/*
 * Output FIFO of decoded characters, flip-flop storage.
 * Assumes a valid/ready producer on the interface and a stalling consumer.
 */
`timescale 1ns/1ps
`default_nettype none
module rx_char_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // filling side
    char_stream_if.snk s_in,
    // draining side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_idx_r;
    logic [AW-1:0] rd_idx_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;
    // handshakes
    assign s_in.ready = (count_r != FULL_CNT);
    assign o_valid = (count_r != '0);
    assign o_data = mem[rd_idx_r];
    assign push = s_in.valid && s_in.ready;
    assign pop = o_valid && i_ready;
    // storage
    always_ff @(posedge i_clk)
    begin
        if (push)
            mem[wr_idx_r] <= s_in.data;
    end
    // pointers and fill count
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            wr_idx_r <= '0;
            rd_idx_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
                wr_idx_r <= (wr_idx_r == AW'(DEPTH - 1)) ? '0 : wr_idx_r + 1'b1;
            if (pop)
                rd_idx_r <= (rd_idx_r == AW'(DEPTH - 1)) ? '0 : rd_idx_r + 1'b1;
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    a_fifo_bound: assert property (@(posedge i_clk) disable iff (!i_nrst)
        count_r <= FULL_CNT) else $error("output fifo count beyond depth");
    a_fifo_count: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (push && !pop) |=> count_r == $past(count_r) + 1'b1) else $error("push lost in output fifo");
endmodule
`default_nettype wire

// file: rx_elastic_buffer.sv
/*
 * Receive elastic buffer with idle-based clock correction, feeding an
 * output FIFO. Assumes the link clock and characters come from pins,
 * characters stable around the link clock rising edge, and a read tick
 * from core logic at the nominal character rate.
 */
// Notes on behaviour
// [RULE1] one entry holds exactly one decoded character
// [RULE2] correct offset only in interframe gaps
// [RULE3] each gap steers fill back to half
// [RULE4] margins absorb one edge per 5000
// [RULE5] logic variant marks 64, 122, 6
// [RULE6] ten-bit 1000BASE-X marks 16, 30, 2
// [RULE7] transceiver variant marks 32, 52, 12
// [RULE8] fill settles within two of half
// [RULE9] mark reached inside frame is error
// [RULE10] logic buffer serves sgmii over lvds
// [RULE11] ten-bit sgmii uses logic buffer sizes
// [RULE12] configurable thresholds bound the restored fill
// [RULE13] only second idle added or removed
// [RULE14] link-side writes, core-side reads, gray pointers
// [RULE15] separate overflow and underflow status flags
`timescale 1ns/1ps
`default_nettype none
module rx_elastic_buffer
    import rx_elastic_pkg::*;
#(
    parameter buf_mode_e MODE = MODE_LOGIC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // link side pins
    input wire logic i_rx_link_clk,
    input wire logic [7:0] i_rx_char,
    input wire logic i_rx_is_k,
    // correction thresholds, used by the configurable variant
    input wire logic [7:0] i_upper_correction_threshold,
    input wire logic [7:0] i_lower_correction_threshold,
    // core side read pacing
    input wire logic i_rd_tick,
    // character output
    output logic o_valid,
    output logic [7:0] o_char,
    output logic o_is_k,
    input wire logic i_ready,
    // status
    input wire logic i_err_clear,
    output logic o_overflow,
    output logic o_underflow,
    output logic [7:0] o_occupancy
);
    // ****************************************
    // variant figures
    // ****************************************
    localparam int DEPTH = mode_figure(MODE, 0); // [RULE5] [RULE6] [RULE7] [RULE10] [RULE11]
    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;
    localparam logic [7:0] HALF8 = 8'(mode_figure(MODE, 1));
    localparam logic [7:0] OVER8 = 8'(mode_figure(MODE, 2));
    localparam logic [7:0] UNDER8 = 8'(mode_figure(MODE, 3));
    localparam logic [7:0] BAND8 = 8'(SETTLE_BAND - 2); // a whole idle moves the fill by two
    localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
    localparam logic [CHAR_W-1:0] IDLE_K = {1'b1, CH_K28_5};
    localparam logic [CHAR_W-1:0] IDLE_D = {1'b0, CH_D16_2};
    localparam logic [CHAR_W-1:0] SOP_C = {1'b1, CH_SOP};
    localparam logic [CHAR_W-1:0] EOP_C = {1'b1, CH_EOP};

    // gray to binary, used for both pointers
    function automatic logic [PW-1:0] g2b(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = '0;
        for (int i = PW - 1; i >= 0; i--)
            b[i] = (i == PW - 1) ? g[i] : (b[i+1] ^ g[i]);
        return b;
    endfunction

    // binary to gray
    function automatic logic [PW-1:0] b2g(input logic [PW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [SYNC_STAGES-1:0] lclk_sync_r;
    logic [CHAR_W-1:0] dat_sync_r [SYNC_STAGES];
    logic lclk_lvl_r;
    logic wr_tick;
    logic [CHAR_W-1:0] new_char;

    // three stages per pin, last two link clock stages must agree
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            lclk_sync_r <= '0;
            for (int i = 0; i < SYNC_STAGES; i++)
                dat_sync_r[i] <= '0;
        end
        else
        begin
            lclk_sync_r <= {lclk_sync_r[SYNC_STAGES-2:0], i_rx_link_clk};
            dat_sync_r[0] <= {i_rx_is_k, i_rx_char};
            for (int i = 1; i < SYNC_STAGES; i++)
                dat_sync_r[i] <= dat_sync_r[i-1];
        end
    end

    // accepted link clock level, updated once stages agree
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            lclk_lvl_r <= 1'b0;
        else if (lclk_sync_r[1] == lclk_sync_r[2])
            lclk_lvl_r <= lclk_sync_r[2];
    end

    // one write slot per link rising edge
    assign wr_tick = (lclk_sync_r[1] == lclk_sync_r[2]) && lclk_sync_r[2] && !lclk_lvl_r; // [RULE14]
    assign new_char = dat_sync_r[2];

    // ****************************************
    // storage and occupancy
    // ****************************************
    logic [CHAR_W-1:0] mem [DEPTH]; // [RULE1]
    logic [PW-1:0] wr_gray_r;
    logic [PW-1:0] rd_gray_r;
    logic [PW-1:0] wr_bin;
    logic [PW-1:0] rd_bin;
    logic [PW-1:0] occ;
    logic [7:0] occ8;
    logic [7:0] upper_thr;
    logic [7:0] lower_thr;
    logic full;
    logic empty;

    // fill level from the gray pointers
    assign wr_bin = g2b(wr_gray_r); // [RULE14]
    assign rd_bin = g2b(rd_gray_r);
    assign occ = wr_bin - rd_bin;
    assign occ8 = 8'(occ);
    assign full = (occ == DEPTH_P);
    assign empty = (occ == '0);

    // correction window, fixed band or software thresholds
    assign upper_thr = (MODE == MODE_XCVR_CFG) ? i_upper_correction_threshold : HALF8 + BAND8; // [RULE12] [RULE8]
    assign lower_thr = (MODE == MODE_XCVR_CFG) ? i_lower_correction_threshold : HALF8 - BAND8; // [RULE12] [RULE8]

    // ****************************************
    // write side
    // ****************************************
    logic [CHAR_W-1:0] hold_r;
    logic hold_vld_r;
    logic wr_in_frame_r;
    logic i2_pair;
    logic del_pair;
    logic wr_en;

    // a held comma followed by the idle data byte forms a removable idle
    assign i2_pair = hold_vld_r && (hold_r == IDLE_K) && (new_char == IDLE_D); // [RULE13]
    assign del_pair = wr_tick && i2_pair && !wr_in_frame_r && (occ8 > upper_thr); // [RULE2] [RULE3]
    assign wr_en = wr_tick && hold_vld_r && !del_pair && !full;

    // one character held back so a whole idle can be dropped
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            hold_r <= '0;
            hold_vld_r <= 1'b0;
        end
        else if (wr_tick)
        begin
            hold_r <= new_char;
            hold_vld_r <= !del_pair;
        end
    end

    // frame tracking as characters arrive
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            wr_in_frame_r <= 1'b0;
        else if (wr_tick && new_char == SOP_C)
            wr_in_frame_r <= 1'b1;
        else if (wr_tick && new_char == EOP_C)
            wr_in_frame_r <= 1'b0;
    end

    // storage write
    always_ff @(posedge i_clk)
    begin
        if (wr_en)
            mem[wr_bin[AW-1:0]] <= hold_r;
    end

    // write pointer
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            wr_gray_r <= '0;
        else if (wr_en)
            wr_gray_r <= b2g(wr_bin + 1'b1); // [RULE14]
    end

    // ****************************************
    // read side
    // ****************************************
    char_stream_if #(.W(CHAR_W)) out_s ();
    rd_state_e rd_state_r;
    rd_state_e rd_state_nxt;
    logic [CHAR_W-1:0] emit_char;
    logic emit;
    logic pop;
    logic last_k_r;
    logic rd_in_frame_r;
    logic go_insert;
    logic can_emit;

    assign can_emit = i_rd_tick && out_s.ready;

    // choose the character sent this slot
    always_comb
    begin
        emit = 1'b0;
        pop = 1'b0;
        emit_char = mem[rd_bin[AW-1:0]];
        case (rd_state_r)
            RD_PASS:
            begin
                emit = can_emit && !empty;
                pop = emit;
            end
            RD_INS_K:
            begin
                emit = can_emit;
                emit_char = IDLE_K; // [RULE13]
            end
            RD_INS_D:
            begin
                emit = can_emit;
                emit_char = IDLE_D;
            end
            default:
            begin
                emit = 1'b0;
            end
        endcase
    end

    // an idle just completed in the gap is repeated while the fill is low
    assign go_insert = emit && (emit_char == IDLE_D) && (last_k_r || rd_state_r == RD_INS_D)
                       && !rd_in_frame_r && (occ8 < lower_thr); // [RULE2] [RULE3]

    // insertion sequencer
    always_comb
    begin
        rd_state_nxt = rd_state_r;
        case (rd_state_r)
            RD_PASS:
                if (go_insert)
                    rd_state_nxt = RD_INS_K;
            RD_INS_K:
                if (emit)
                    rd_state_nxt = RD_INS_D;
            RD_INS_D:
                if (go_insert)
                    rd_state_nxt = RD_INS_K;
                else if (emit)
                    rd_state_nxt = RD_PASS;
            default:
                rd_state_nxt = RD_PASS;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            rd_state_r <= RD_PASS;
        else
            rd_state_r <= rd_state_nxt;
    end

    // last emitted was a comma, and frame tracking on the read side
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            last_k_r <= 1'b0;
            rd_in_frame_r <= 1'b0;
        end
        else if (emit)
        begin
            last_k_r <= (emit_char == IDLE_K);
            if (emit_char == SOP_C)
                rd_in_frame_r <= 1'b1;
            else if (emit_char == EOP_C)
                rd_in_frame_r <= 1'b0;
        end
    end

    // read pointer
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            rd_gray_r <= '0;
        else if (pop)
            rd_gray_r <= b2g(rd_bin + 1'b1); // [RULE14]
    end

    assign out_s.valid = emit;
    assign out_s.data = emit_char;

    // ****************************************
    // status
    // ****************************************
    logic overflow_r;
    logic underflow_r;
    logic ovf_event;
    logic unf_event;
    logic [7:0] occ_r;

    // marks are placed so drift over a legal frame stays clear of them
    // a removed idle is no write, so it cannot overflow a full buffer
    assign ovf_event = (wr_in_frame_r && wr_en && occ8 >= OVER8) // [RULE9] [RULE4]
                       || (wr_tick && hold_vld_r && !del_pair && full);
    assign unf_event = (rd_in_frame_r && i_rd_tick && occ8 <= UNDER8); // [RULE9] [RULE4]

    // sticky flags, a new event wins over a clear
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            overflow_r <= 1'b0;
            underflow_r <= 1'b0;
        end
        else
        begin
            overflow_r <= ovf_event || (overflow_r && !i_err_clear); // [RULE15]
            underflow_r <= unf_event || (underflow_r && !i_err_clear); // [RULE15]
        end
    end

    // registered fill level
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            occ_r <= '0;
        else
            occ_r <= occ8;
    end

    assign o_overflow = overflow_r;
    assign o_underflow = underflow_r;
    assign o_occupancy = occ_r;

    // ****************************************
    // output fifo
    // ****************************************
    logic [CHAR_W-1:0] out_word;

    rx_char_fifo #(.WIDTH(CHAR_W), .DEPTH(OUT_FIFO_DEPTH)) u_out_fifo (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .s_in(out_s.snk),
        .o_valid(o_valid),
        .o_data(out_word),
        .i_ready(i_ready)
    );

    assign o_char = out_word[7:0];
    assign o_is_k = out_word[8];

    // ****************************************
    // checks
    // ****************************************
    a_occ_bound: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE14]
        occ <= DEPTH_P) else $error("elastic fill beyond depth");
    a_delete_gap: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE2]
        del_pair |-> !wr_in_frame_r && hold_r == IDLE_K) else $error("idle removed inside frame");
    a_delete_high: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE3]
        del_pair |=> !hold_vld_r && $stable(wr_gray_r)) else $error("removed idle was stored");
    a_insert_gap: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE2]
        (rd_state_r == RD_PASS && rd_state_nxt == RD_INS_K) |-> !rd_in_frame_r && occ8 < lower_thr)
        else $error("idle inserted inside frame or above threshold");
    a_insert_pair: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE13]
        (rd_state_r == RD_INS_K && emit) |-> out_s.data == IDLE_K ##1 rd_state_r == RD_INS_D)
        else $error("inserted idle not a comma then data pair");
    a_insert_hold: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE13]
        (rd_state_r != RD_PASS) |=> $stable(rd_gray_r)) else $error("read pointer moved while inserting");
    a_over_flag: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE9]
        (wr_in_frame_r && wr_en && occ8 >= OVER8) |=> o_overflow ##1 (o_overflow || $past(i_err_clear)))
        else $error("overflow not flagged");
    a_under_flag: assert property (@(posedge i_clk) disable iff (!i_nrst) // [RULE15]
        (rd_in_frame_r && i_rd_tick && occ8 <= UNDER8) |=> o_underflow) else $error("underflow not flagged");
endmodule
`default_nettype wire

// file: rx_elastic_buffer_test.sv
/*
 * Self-checking bench: five buffer variants side by side, fed by one
 * link source, core-side reads paced, stalled or free-running.
 * Assumes the package, design files and source model compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module rx_elastic_buffer_test
    import rx_elastic_pkg::*;
;
    localparam int N = 5;
    localparam buf_mode_e MODES [N] = '{MODE_LOGIC, MODE_TBI_1000X, MODE_TBI_SGMII, MODE_XCVR, MODE_XCVR_CFG};
    localparam int HALF [N] = '{LOGIC_HALF, TBI_HALF, LOGIC_HALF, XCVR_HALF, XCVR_HALF};
    localparam int UNDER [N] = '{LOGIC_UNDER, TBI_UNDER, LOGIC_UNDER, XCVR_UNDER, XCVR_UNDER};
    logic clk, nrst, rd_tick, ready, err_clear, link_clk, rx_is_k;
    logic [7:0] rx_char;
    logic [1:0] rd_mode;
    logic [2:0] pace;
    logic [7:0] occ [N];
    logic [7:0] ch [N];
    logic vld [N];
    logic isk [N];
    logic ovf [N];
    logic unf [N];
    logic [8:0] got [$];
    logic [8:0] exp_q [$];
    int n_errors;
    int n_checks;
    // ****************************************
    // clock, partner and the variants
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    link_char_src src_u (.o_link_clk(link_clk), .o_char(rx_char), .o_is_k(rx_is_k));
    // thresholds equal, midway between the marks 52 and 12
    for (genvar g = 0; g < N; g++)
    begin : g_var
        rx_elastic_buffer #(.MODE(MODES[g])) dut_u (
            .i_clk(clk), .i_nrst(nrst), .i_rx_link_clk(link_clk), .i_rx_char(rx_char), .i_rx_is_k(rx_is_k),
            .i_upper_correction_threshold(8'h20), .i_lower_correction_threshold(8'h20),
            .i_rd_tick(rd_tick), .o_valid(vld[g]), .o_char(ch[g]), .o_is_k(isk[g]), .i_ready(ready),
            .i_err_clear(err_clear), .o_overflow(ovf[g]), .o_underflow(unf[g]), .o_occupancy(occ[g]));
    end
    // read slots: none, one per link period, or every cycle
    initial
    begin
        pace = 3'h0;
        rd_tick = 1'b0;
        forever
        begin
            @(posedge clk);
            #2;
            pace = pace + 3'h1;
            rd_tick = (rd_mode == 2'h2) || (rd_mode == 2'h1 && pace == 3'h0);
        end
    end
    // collect non-idle characters taken from the first variant, settled mid-cycle
    always @(negedge clk)
        if (vld[0] === 1'b1 && ready === 1'b1 && !({isk[0], ch[0]} inside {{1'b1, CH_K28_5}, {1'b0, CH_D16_2}}))
            got.push_back({isk[0], ch[0]});
    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic clear_flags();
        err_clear = 1'b1;
        cyc(1);
        err_clear = 1'b0;
        cyc(2);
    endtask
    // frame of n data bytes, optional carrier extend, sent whole
    task automatic send_frame(input int n, input bit ext);
        int k;
        exp_q.delete();
        exp_q.push_back({1'b1, CH_SOP});
        for (int i = 0; i < n; i++)
            exp_q.push_back(9'(16 + i));
        exp_q.push_back({1'b1, CH_EOP});
        if (ext)
            exp_q.push_back(9'h1f7);
        foreach (exp_q[i])
            src_u.push(exp_q[i]);
        k = 0;
        while (src_u.q.size() != 0 && k < 4000)
        begin
            cyc(1);
            k++;
        end
        if (k == 4000)
        begin
            n_errors++;
            end_of_test();
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        for (int g = 0; g < N; g++)
        begin
            check({vld[g], ovf[g], unf[g]}, 3'h0);
            check(occ[g], 8'h00);
        end
    endtask
    // idles inserted keep a fast reader fed, frame passes whole
    task automatic t_pass_through();
        ready = 1'b1;
        rd_mode = 2'h2;
        cyc(1500);
        for (int g = 0; g < N; g++)
        begin
            check(unf[g], 1'b0);
            check(occ[g] > UNDER[g], 1'b1);
        end
        rd_mode = 2'h1;
        cyc(200);
        got.delete();
        send_frame(19, 1'b1);
        cyc(700);
        check(got.size(), exp_q.size());
        foreach (exp_q[i])
            check(got[i], exp_q[i]);
        check({ovf[0], unf[0]}, 2'h0);
    endtask
    // no reads: idle removal holds fill near half
    task automatic t_fill_band();
        ready = 1'b0;
        rd_mode = 2'h0;
        cyc(1200);
        for (int g = 0; g < N; g++)
        begin
            check(occ[g] >= HALF[g] - SETTLE_BAND && occ[g] <= HALF[g] + SETTLE_BAND, 1'b1);
            check(ovf[g], 1'b0);
        end
    endtask
    // frame while stalled reaches every overflow mark
    task automatic t_overflow();
        send_frame(60, 1'b0);
        cyc(20);
        for (int g = 0; g < N; g++)
            check(ovf[g], 1'b1);
        check(unf[0], 1'b0);
        clear_flags();
        check(ovf[0], 1'b0);
    endtask
    // fast reads inside a frame reach every underflow mark
    task automatic t_underflow();
        ready = 1'b1;
        rd_mode = 2'h2;
        cyc(1500);
        clear_flags();
        check({ovf[0], unf[0]}, 2'h0);
        send_frame(100, 1'b0);
        cyc(20);
        for (int g = 0; g < N; g++)
            check(unf[g], 1'b1);
        check(ovf[0], 1'b0);
        cyc(200);
        clear_flags();
        check(unf[0], 1'b0);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        nrst = 1'b0;
        ready = 1'b0;
        err_clear = 1'b0;
        rd_mode = 2'h0;
        n_errors = 0;
        n_checks = 0;
        cyc(16);
        t_reset();
        nrst = 1'b1;
        t_pass_through();
        t_fill_band();
        t_overflow();
        t_underflow();
        end_of_test();
    end
endmodule
`default_nettype wire

// file: rx_elastic_pkg.sv
/*
 * Shared constants for the receive elastic buffer: character codes,
 * buffer variants with their depths and marks, drift figures, state codes.
 * Assumes decoded characters arrive as one byte plus a control flag.
 */
package rx_elastic_pkg;
    // ****************************************
    // characters
    // ****************************************
    localparam int CHAR_W = 9; // control flag above one decoded byte
    localparam logic [7:0] CH_K28_5 = 8'hbc; // comma, first half of an idle
    localparam logic [7:0] CH_D16_2 = 8'h50; // second half of the correctable idle
    localparam logic [7:0] CH_SOP = 8'hfb; // start of packet
    localparam logic [7:0] CH_EOP = 8'hfd; // end of packet
    // ****************************************
    // drift and settling
    // ****************************************
    localparam int PPM_PER_SIDE = 100;
    localparam int NOMINAL_MHZ = 125;
    localparam int DRIFT_PERIODS = 1000000 / (2 * PPM_PER_SIDE); // one edge per this many periods
    localparam int SETTLE_BAND = 2; // entries either side of half full
    localparam int SYNC_STAGES = 3;
    localparam int OUT_FIFO_DEPTH = 16;
    // ****************************************
    // variants
    // ****************************************
    typedef enum logic [4:0] {MODE_LOGIC = 5'h01, MODE_TBI_1000X = 5'h02, MODE_TBI_SGMII = 5'h04,
                              MODE_XCVR = 5'h08, MODE_XCVR_CFG = 5'h10} buf_mode_e;
    typedef enum logic [2:0] {RD_PASS = 3'h1, RD_INS_K = 3'h2, RD_INS_D = 3'h4} rd_state_e;
    localparam int LOGIC_DEPTH = 128;
    localparam int LOGIC_HALF = 64;
    localparam int LOGIC_OVER = 122;
    localparam int LOGIC_UNDER = 6;
    localparam int TBI_DEPTH = 32;
    localparam int TBI_HALF = 16;
    localparam int TBI_OVER = 30;
    localparam int TBI_UNDER = 2;
    localparam int XCVR_DEPTH = 64;
    localparam int XCVR_HALF = 32;
    localparam int XCVR_OVER = 52;
    localparam int XCVR_UNDER = 12;
    // variant figures, sgmii over the ten-bit interface uses the logic buffer
    function automatic int mode_figure(buf_mode_e m, int sel);
        int v [3];
        v = '{LOGIC_DEPTH, LOGIC_HALF, LOGIC_OVER};
        if (m == MODE_TBI_1000X)
            v = '{TBI_DEPTH, TBI_HALF, TBI_OVER};
        else if (m == MODE_XCVR || m == MODE_XCVR_CFG)
            v = '{XCVR_DEPTH, XCVR_HALF, XCVR_OVER};
        if (sel < 3)
            return v[sel];
        if (m == MODE_TBI_1000X)
            return TBI_UNDER;
        if (m == MODE_XCVR || m == MODE_XCVR_CFG)
            return XCVR_UNDER;
        return LOGIC_UNDER;
    endfunction
endpackage
